/* File: rcr_pkg.sv */
// Constants for the regulator control register bank
`default_nettype none

package rcr_pkg;

    // ------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------
    localparam int NUM_BUCK = 4;
    localparam int NUM_LDO  = 2;
    localparam int NUM_REG  = NUM_BUCK + NUM_LDO;
    localparam int CODE_W   = 6;

    typedef logic [7:0]        rcr_byte_t;
    typedef logic [CODE_W-1:0] rcr_code_t;

    // ------------------------------------------------------------
    // Register offsets, index 0..3 bucks, 4..5 LDOs
    // ------------------------------------------------------------
    localparam rcr_byte_t RCR_PRI_OFF  [NUM_BUCK] = '{8'h10, 8'h20, 8'h30, 8'h40};
    localparam rcr_byte_t RCR_SEC_OFF  [NUM_BUCK] = '{8'h11, 8'h21, 8'h31, 8'h41};
    localparam rcr_byte_t RCR_LDO_OFF  [NUM_LDO]  = '{8'h50, 8'h58};
    localparam rcr_byte_t RCR_CTRL_OFF [NUM_REG]  =
        '{8'h12, 8'h22, 8'h32, 8'h42, 8'h51, 8'h59};

    // ------------------------------------------------------------
    // Control register field positions
    // ------------------------------------------------------------
    localparam int RCR_ON_BIT   = 7;
    localparam int RCR_MODE_BIT = 2;
    localparam int RCR_FLT_BIT  = 1;
    localparam int RCR_PG_BIT   = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam rcr_code_t RCR_CODE_RST = 6'h00;
    localparam logic      RCR_ON_RST   = 1'b0;
    localparam logic      RCR_MODE_RST = 1'b0;
    localparam logic      RCR_FLT_RST  = 1'b0;
    localparam rcr_byte_t RCR_RD_NONE  = 8'h00;

endpackage

`default_nettype wire

/* File: rcr_chan.sv */
// One regulator's control bits, power-good tracking and fault event
`timescale 1ns/100ps
`default_nettype none

module rcr_chan (
    // Clock and reset
    input  wire logic           clk_sys,
    input  wire logic           rst_n,
    // Control register write
    input  wire logic           wr_ctrl,
    input  wire rcr_pkg::rcr_byte_t wdata,
    // Regulator status
    input  wire logic           power_good,
    // Control state
    output logic                on,
    output logic                mode,
    output logic                fault_interrupt_enable,
    output logic                power_good_q,
    output logic                fault_event
);
    import rcr_pkg::*;

    logic next_on;
    logic next_mode;
    logic next_fault_interrupt_enable;
    logic next_fault_event;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        next_on                     = on;
        next_mode                   = mode;
        next_fault_interrupt_enable = fault_interrupt_enable;
        if (wr_ctrl) begin
            next_on                     = wdata[RCR_ON_BIT];
            next_mode                   = wdata[RCR_MODE_BIT];
            next_fault_interrupt_enable = wdata[RCR_FLT_BIT];
        end
        // Only a falling edge counts, so a regulator still ramping up raises nothing
        next_fault_event = power_good_q & ~power_good & on & fault_interrupt_enable;
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            on                     <= RCR_ON_RST;
            mode                   <= RCR_MODE_RST;
            fault_interrupt_enable <= RCR_FLT_RST;
            power_good_q           <= 1'b0;
            fault_event            <= 1'b0;
        end else begin
            on                     <= next_on;
            mode                   <= next_mode;
            fault_interrupt_enable <= next_fault_interrupt_enable;
            power_good_q           <= power_good;
            fault_event            <= next_fault_event;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_fault_on_drop;
        @(posedge clk_sys) disable iff (!rst_n)
        ($fell(power_good) && on && fault_interrupt_enable) |=> fault_event;
    endproperty
    a_fault_on_drop: assert property (p_fault_on_drop)
        else $error("power-good drop on enabled regulator raised no fault");

    property p_fault_masked;
        @(posedge clk_sys) disable iff (!rst_n)
        fault_event |-> $past(fault_interrupt_enable) && $past(on);
    endproperty
    a_fault_masked: assert property (p_fault_masked)
        else $error("fault event raised while masked or off");

    property p_on_write;
        @(posedge clk_sys) disable iff (!rst_n)
        wr_ctrl |=> (on == $past(wdata[RCR_ON_BIT])) && (mode == $past(wdata[RCR_MODE_BIT]));
    endproperty
    a_on_write: assert property (p_on_write)
        else $error("control write not taken");

    property p_pg_track;
        @(posedge clk_sys) disable iff (!rst_n)
        ##1 power_good_q == $past(power_good);
    endproperty
    a_pg_track: assert property (p_pg_track)
        else $error("power-good status does not follow input");

endmodule // rcr_chan

`default_nettype wire

/* File: rcr_regs.sv */
// Control and status register bank for four bucks and two LDOs
// What this block does
// - Buck targets use the primary voltage code while the select pin is low.
// - Buck targets use the secondary voltage code while the select pin is high.
// - Each LDO uses one voltage code of its own, ignoring the select pin.
// - Control bit 7 turns its regulator on when one, off when zero.
// - Buck control bit 2 set switches that buck 180 degrees out of phase.
// - LDO control bit 2 set enables output discharge while the LDO is off.
// - Control bit 1 lets that regulator's faults raise interrupts; zero suppresses them.
// - Read-only control bit 0 shows the regulator's power-good status.
`timescale 1ns/100ps
`default_nettype none

module rcr_regs (
    // Clock and reset
    input  wire logic                 clk_sys,
    input  wire logic                 rst_n,
    // Register port from the serial interface engine
    input  wire rcr_pkg::rcr_byte_t   reg_addr,
    input  wire rcr_pkg::rcr_byte_t   reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output rcr_pkg::rcr_byte_t        reg_rdata,
    output logic                      reg_rvalid,
    // Device pins and regulator status
    input  wire logic                 voltage_select_pin,
    input  wire logic [5:0]           power_good,
    // Regulator controls
    output rcr_pkg::rcr_code_t        vout_target [6],
    output logic [5:0]                regulator_on,
    output logic [3:0]                phase_shift,
    output logic [1:0]                output_discharge_active,
    output logic [5:0]                fault_event
);
    import rcr_pkg::*;

    // ------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------
    rcr_code_t primary_voltage_code   [NUM_BUCK];
    rcr_code_t secondary_voltage_code [NUM_BUCK];
    rcr_code_t voltage_code           [NUM_LDO];
    rcr_code_t next_primary_voltage_code   [NUM_BUCK];
    rcr_code_t next_secondary_voltage_code [NUM_BUCK];
    rcr_code_t next_voltage_code           [NUM_LDO];
    rcr_code_t next_vout_target            [NUM_REG];

    logic [NUM_REG-1:0]  wr_ctrl;
    logic [NUM_REG-1:0]  ch_mode;
    logic [NUM_REG-1:0]  ch_fault_en;
    logic [NUM_REG-1:0]  ch_pg;
    logic [3:0]          next_phase_shift;
    logic [1:0]          next_output_discharge_active;
    rcr_byte_t           next_reg_rdata;
    logic                next_reg_rvalid;

    // ------------------------------------------------------------
    // Per-regulator control registers
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < NUM_REG; g++) begin : g_chan
            assign wr_ctrl[g] = reg_wr && (reg_addr == RCR_CTRL_OFF[g]);
            rcr_chan u_chan (
                .clk_sys                (clk_sys),
                .rst_n                  (rst_n),
                .wr_ctrl                (wr_ctrl[g]),
                .wdata                  (reg_wdata),
                .power_good             (power_good[g]),
                .on                     (regulator_on[g]),
                .mode                   (ch_mode[g]),
                .fault_interrupt_enable (ch_fault_en[g]),
                .power_good_q           (ch_pg[g]),
                .fault_event            (fault_event[g])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // Voltage code writes
    // ------------------------------------------------------------
    always_comb begin
        for (int i = 0; i < NUM_BUCK; i++) begin
            next_primary_voltage_code[i]   = primary_voltage_code[i];
            next_secondary_voltage_code[i] = secondary_voltage_code[i];
            if (reg_wr && reg_addr == RCR_PRI_OFF[i]) begin
                next_primary_voltage_code[i] = reg_wdata[CODE_W-1:0];
            end
            if (reg_wr && reg_addr == RCR_SEC_OFF[i]) begin
                next_secondary_voltage_code[i] = reg_wdata[CODE_W-1:0];
            end
        end
        for (int j = 0; j < NUM_LDO; j++) begin
            next_voltage_code[j] = voltage_code[j];
            if (reg_wr && reg_addr == RCR_LDO_OFF[j]) begin
                next_voltage_code[j] = reg_wdata[CODE_W-1:0];
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_BUCK; i++) begin
                primary_voltage_code[i]   <= RCR_CODE_RST;
                secondary_voltage_code[i] <= RCR_CODE_RST;
            end
            for (int j = 0; j < NUM_LDO; j++) begin
                voltage_code[j] <= RCR_CODE_RST;
            end
        end else begin
            primary_voltage_code   <= next_primary_voltage_code;
            secondary_voltage_code <= next_secondary_voltage_code;
            voltage_code           <= next_voltage_code;
        end
    end

    // ------------------------------------------------------------
    // Regulator-facing outputs
    // ------------------------------------------------------------
    // Registered so the analog side never sees a decode glitch; costs one cycle
    always_comb begin
        for (int i = 0; i < NUM_BUCK; i++) begin
            if (voltage_select_pin) begin
                next_vout_target[i] = secondary_voltage_code[i];
            end else begin
                next_vout_target[i] = primary_voltage_code[i];
            end
        end
        for (int j = 0; j < NUM_LDO; j++) begin
            next_vout_target[NUM_BUCK+j] = voltage_code[j];
        end
        next_phase_shift = ch_mode[NUM_BUCK-1:0];
        // Discharge only acts while the LDO is shut down
        next_output_discharge_active =
            ch_mode[NUM_REG-1:NUM_BUCK] & ~regulator_on[NUM_REG-1:NUM_BUCK];
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int k = 0; k < NUM_REG; k++) begin
                vout_target[k] <= RCR_CODE_RST;
            end
            phase_shift             <= '0;
            output_discharge_active <= '0;
        end else begin
            vout_target             <= next_vout_target;
            phase_shift             <= next_phase_shift;
            output_discharge_active <= next_output_discharge_active;
        end
    end

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Reserved and unmapped bits read as zero
    always_comb begin
        next_reg_rdata  = RCR_RD_NONE;
        next_reg_rvalid = reg_rd;
        if (reg_rd) begin
            for (int i = 0; i < NUM_BUCK; i++) begin
                if (reg_addr == RCR_PRI_OFF[i]) begin
                    next_reg_rdata = {2'b00, primary_voltage_code[i]};
                end
                if (reg_addr == RCR_SEC_OFF[i]) begin
                    next_reg_rdata = {2'b00, secondary_voltage_code[i]};
                end
            end
            for (int j = 0; j < NUM_LDO; j++) begin
                if (reg_addr == RCR_LDO_OFF[j]) begin
                    next_reg_rdata = {2'b00, voltage_code[j]};
                end
            end
            for (int k = 0; k < NUM_REG; k++) begin
                if (reg_addr == RCR_CTRL_OFF[k]) begin
                    next_reg_rdata = {regulator_on[k], 4'h0, ch_mode[k],
                                      ch_fault_en[k], ch_pg[k]};
                end
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata  <= RCR_RD_NONE;
            reg_rvalid <= 1'b0;
        end else begin
            reg_rdata  <= next_reg_rdata;
            reg_rvalid <= next_reg_rvalid;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_buck_primary;
        @(posedge clk_sys) disable iff (!rst_n)
        !voltage_select_pin |=> vout_target[1] == $past(primary_voltage_code[1]);
    endproperty
    a_buck_primary: assert property (p_buck_primary)
        else $error("buck target not primary code with select low");

    property p_buck_secondary;
        @(posedge clk_sys) disable iff (!rst_n)
        voltage_select_pin |=> vout_target[2] == $past(secondary_voltage_code[2]);
    endproperty
    a_buck_secondary: assert property (p_buck_secondary)
        else $error("buck target not secondary code with select high");

    property p_ldo_code;
        @(posedge clk_sys) disable iff (!rst_n)
        (reg_wr && reg_addr == RCR_LDO_OFF[0]) |=> ##1
            vout_target[NUM_BUCK] == $past(reg_wdata[CODE_W-1:0], 2);
    endproperty
    a_ldo_code: assert property (p_ldo_code)
        else $error("LDO target did not follow its code write");

    property p_phase;
        @(posedge clk_sys) disable iff (!rst_n)
        (reg_wr && reg_addr == RCR_CTRL_OFF[0]) |=> ##1
            phase_shift[0] == $past(reg_wdata[RCR_MODE_BIT], 2);
    endproperty
    a_phase: assert property (p_phase)
        else $error("phase control not applied");

    property p_discharge;
        @(posedge clk_sys) disable iff (!rst_n)
        output_discharge_active[0] |-> $past(!regulator_on[NUM_BUCK]);
    endproperty
    a_discharge: assert property (p_discharge)
        else $error("discharge active while LDO on");

    property p_read_ctrl;
        @(posedge clk_sys) disable iff (!rst_n)
        (reg_rd && reg_addr == RCR_CTRL_OFF[3]) |=>
            reg_rvalid && reg_rdata[RCR_PG_BIT] == $past(ch_pg[3])
            && reg_rdata[6:3] == 4'h0;
    endproperty
    a_read_ctrl: assert property (p_read_ctrl)
        else $error("control read wrong");

    // Between answers the data lines sit at zero, so a late sampler sees no stale byte
    property p_read_idle;
        @(posedge clk_sys) disable iff (!rst_n)
        !reg_rvalid |-> (reg_rdata == RCR_RD_NONE);
    endproperty
    a_read_idle: assert property (p_read_idle)
        else $error("read data not cleared between answers");

    property p_pri_write;
        @(posedge clk_sys) disable iff (!rst_n)
        (reg_wr && reg_addr == RCR_PRI_OFF[0])
            |=> (primary_voltage_code[0] == $past(reg_wdata[CODE_W-1:0]));
    endproperty
    a_pri_write: assert property (p_pri_write)
        else $error("primary code write not taken");

    property p_sec_write;
        @(posedge clk_sys) disable iff (!rst_n)
        (reg_wr && reg_addr == RCR_SEC_OFF[3])
            |=> (secondary_voltage_code[3] == $past(reg_wdata[CODE_W-1:0]));
    endproperty
    a_sec_write: assert property (p_sec_write)
        else $error("secondary code write not taken");

    // Every buck, not only one, follows the select pin a cycle later
    generate
        for (g = 0; g < NUM_BUCK; g++) begin : g_buck_chk
            property p_buck_select;
                @(posedge clk_sys) disable iff (!rst_n)
                ##1 (vout_target[g] == ($past(voltage_select_pin)
                                        ? $past(secondary_voltage_code[g])
                                        : $past(primary_voltage_code[g])));
            endproperty
            a_buck_select: assert property (p_buck_select)
                else $error("buck target does not follow the select pin");

            property p_phase_follow;
                @(posedge clk_sys) disable iff (!rst_n)
                ##1 (phase_shift[g] == $past(ch_mode[g]));
            endproperty
            a_phase_follow: assert property (p_phase_follow)
                else $error("buck phase does not follow its control bit");
        end
    endgenerate

    // The pin never reaches an LDO; its target is its own code alone
    generate
        for (g = 0; g < NUM_LDO; g++) begin : g_ldo_chk
            property p_ldo_follow;
                @(posedge clk_sys) disable iff (!rst_n)
                ##1 (vout_target[NUM_BUCK+g] == $past(voltage_code[g]));
            endproperty
            a_ldo_follow: assert property (p_ldo_follow)
                else $error("LDO target does not follow its own code");

            property p_discharge_follow;
                @(posedge clk_sys) disable iff (!rst_n)
                ##1 (output_discharge_active[g]
                     == ($past(ch_mode[NUM_BUCK+g]) && !$past(regulator_on[NUM_BUCK+g])));
            endproperty
            a_discharge_follow: assert property (p_discharge_follow)
                else $error("LDO discharge does not follow its control bit");
        end
    endgenerate

endmodule // rcr_regs

`default_nettype wire

/* File: rcr_host.sv */
// Host model that reaches the control bank through its byte-wide register port
`timescale 1ns/100ps
`default_nettype none

module rcr_host (
    // Clock
    input  wire logic               clk_sys,
    // Register port
    output rcr_pkg::rcr_byte_t      reg_addr,
    output rcr_pkg::rcr_byte_t      reg_wdata,
    output logic                    reg_wr,
    output logic                    reg_rd,
    input  wire rcr_pkg::rcr_byte_t reg_rdata,
    input  wire logic               reg_rvalid
);
    import rcr_pkg::*;

    initial begin
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
    end

    // Released lines show the inverse, so a stale decode cannot pass
    task automatic wr_reg(input rcr_byte_t a, input rcr_byte_t d);
        @(posedge clk_sys) #1;
        reg_addr  = a;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(posedge clk_sys) #1;
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask

    // The answer stands for one cycle only, so it is taken right away
    task automatic rd_reg(input rcr_byte_t a, output rcr_byte_t d);
        @(posedge clk_sys) #1;
        reg_addr = a;
        reg_rd   = 1'b1;
        @(posedge clk_sys) #1;
        reg_rd   = 1'b0;
        reg_addr = ~a;
        d = (reg_rvalid === 1'b1) ? reg_rdata : 8'hXX;
    endtask
endmodule // rcr_host

`default_nettype wire

/* File: rcr_regs_bench.sv */
// Self-checking bench for the regulator control register bank
`timescale 1ns/100ps
`default_nettype none

module rcr_regs_bench;
    import rcr_pkg::*;

    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic       clk_sys;
    logic       rst_n;
    rcr_byte_t  reg_addr;
    rcr_byte_t  reg_wdata;
    logic       reg_wr;
    logic       reg_rd;
    rcr_byte_t  reg_rdata;
    logic       reg_rvalid;
    logic       voltage_select_pin;
    logic [5:0] power_good;
    rcr_code_t  vout_target [6];
    logic [5:0] regulator_on;
    logic [3:0] phase_shift;
    logic [1:0] output_discharge_active;
    logic [5:0] fault_event;
    int         bad_count = 0;
    int         compares = 0;

    // Address, write data, expected read back
    localparam rcr_byte_t ROWS [16][3] = '{
        '{8'h10, 8'hFF, 8'h3F}, '{8'h11, 8'hC1, 8'h01}, '{8'h20, 8'h42, 8'h02},
        '{8'h21, 8'h3E, 8'h3E}, '{8'h30, 8'h15, 8'h15}, '{8'h31, 8'hAA, 8'h2A},
        '{8'h40, 8'h07, 8'h07}, '{8'h41, 8'h38, 8'h38}, '{8'h50, 8'h5B, 8'h1B},
        '{8'h58, 8'h24, 8'h24}, '{8'h12, 8'hFF, 8'h86}, '{8'h22, 8'h7B, 8'h02},
        '{8'h32, 8'h86, 8'h86}, '{8'h42, 8'h84, 8'h84}, '{8'h51, 8'h04, 8'h04},
        '{8'h59, 8'h82, 8'h82}};
    localparam rcr_code_t VLO [6] = '{6'h3F, 6'h02, 6'h15, 6'h07, 6'h1B, 6'h24};
    localparam rcr_code_t VHI [6] = '{6'h01, 6'h3E, 6'h2A, 6'h38, 6'h1B, 6'h24};

    // ------------------------------------------------------------
    // Clock, parts and watchdog
    // ------------------------------------------------------------
    always #2.5 clk_sys = ~clk_sys;

    rcr_regs i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .voltage_select_pin(voltage_select_pin),
        .power_good(power_good), .vout_target(vout_target), .regulator_on(regulator_on),
        .phase_shift(phase_shift), .output_discharge_active(output_discharge_active),
        .fault_event(fault_event));

    rcr_host i_host (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid));

    // The tests need well under 400 cycles
    initial begin
        #20000;
        bad_count++;
        end_sim();
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        rcr_byte_t  d;
        int         n;
        logic [5:0] seen;
        clk_sys = 1'b0;
        rst_n = 1'b0;
        voltage_select_pin = 1'b0;
        power_good = 6'h00;
        repeat (5) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        for (int i = 0; i < 16; i++) begin
            i_host.rd_reg(ROWS[i][0], d);
            chk(d, 8'h00);
        end
        for (int i = 0; i < 16; i++) begin
            i_host.wr_reg(ROWS[i][0], ROWS[i][1]);
        end
        for (int i = 0; i < 16; i++) begin
            i_host.rd_reg(ROWS[i][0], d);
            chk(d, ROWS[i][2]);
        end
        $display("test rows done");
        chk({2'b00, regulator_on}, 8'h2D);
        chk({4'h0, phase_shift}, 8'h0D);
        chk({6'h00, output_discharge_active}, 8'h01);
        for (int i = 0; i < 6; i++) begin
            chk({2'b00, vout_target[i]}, {2'b00, VLO[i]});
        end
        voltage_select_pin = 1'b1;
        repeat (2) @(posedge clk_sys);
        #1;
        for (int i = 0; i < 6; i++) begin
            chk({2'b00, vout_target[i]}, {2'b00, VHI[i]});
        end
        $display("test select pin done");
        // Unmapped place takes no write and reads as zero
        i_host.wr_reg(8'h13, 8'hFF);
        i_host.rd_reg(8'h13, d);
        chk(d, 8'h00);
        i_host.rd_reg(8'h12, d);
        chk(d, 8'h86);
        $display("test unmapped done");
        power_good = 6'h3F;
        repeat (2) @(posedge clk_sys);
        #1;
        i_host.rd_reg(8'h12, d);
        chk(d, 8'h87);
        i_host.wr_reg(8'h51, 8'h84);
        repeat (2) @(posedge clk_sys);
        #1;
        chk({6'h00, output_discharge_active}, 8'h00);
        i_host.wr_reg(8'h51, 8'h04);
        // Only enabled, unmasked regulators may report the drop
        power_good = 6'h00;
        seen = 6'h00;
        n = 0;
        repeat (4) begin
            @(posedge clk_sys);
            #1;
            seen = seen | fault_event;
            if (fault_event !== 6'h00) n++;
        end
        chk({2'b00, seen}, 8'h25);
        chk(8'(n), 8'h01);
        i_host.rd_reg(8'h12, d);
        chk(d, 8'h86);
        $display("test fault done");
        rst_n = 1'b0;
        @(posedge clk_sys);
        #1;
        chk({2'b00, regulator_on}, 8'h00);
        rst_n = 1'b1;
        i_host.rd_reg(8'h20, d);
        chk(d, 8'h00);
        $display("test reset done");
        end_sim();
    end
endmodule // rcr_regs_bench

`default_nettype wire
